// *** logic/cap_cfg.svh ***
`ifndef CAP_CFG_SVH
`define CAP_CFG_SVH

// ----------------------------------------
// Register map, word slot indices and address groups
// ----------------------------------------
`define CAP_OFS_CMODE 3'h0
`define CAP_OFS_COUNT 3'h1
`define CAP_OFS_STAT 3'h2
`define CAP_OFS_MASK 3'h3
`define CAP_GRP_CTRL 3'h0
`define CAP_GRP_MMODE 3'h1
`define CAP_GRP_CMPL 3'h2
`define CAP_GRP_CMPH 3'h3

// ----------------------------------------
// Counter mode register fields
// ----------------------------------------
`define CAP_CM_RUN 0
`define CAP_CM_SRC_LSB 1
`define CAP_CM_SRC_MSB 2
`define CAP_CM_WATCHDOG_RESET_ENABLE 6

// ----------------------------------------
// Module mode register fields
// ----------------------------------------
`define CAP_MM_ECCF 0
`define CAP_MM_PWM 1
`define CAP_MM_TOG 2
`define CAP_MM_MAT 3
`define CAP_MM_COMPARATOR_ENABLE 6

// ----------------------------------------
// Status bits, counts and reset values
// ----------------------------------------
`define CAP_NMOD 5
`define CAP_WDOG_IDX 4
`define CAP_ST_WRAP 5
`define CAP_ST_WDOG 6
`define CAP_DIV12 4'hc
`define CAP_DIV4 4'h4
`define CAP_LOW_MAX 8'hff
`define CAP_CNT_MAX 16'hffff
`define CAP_RST_BYTE 8'h00
`define CAP_RST_STAT 7'h00

`endif

// *** logic/cap_pkg.sv ***
`default_nettype none
`include "cap_cfg.svh"

package cap_pkg;
  typedef logic [7:0] cap_byte_t;
  typedef enum logic [1:0] {CAP_SRC_DIV12, CAP_SRC_DIV4, CAP_SRC_T0, CAP_SRC_EXT} cap_src_e;

  function automatic logic isPwm(input cap_byte_t m);
    isPwm = m[`CAP_MM_COMPARATOR_ENABLE] & m[`CAP_MM_PWM];
  endfunction

  function automatic logic isCompare(input cap_byte_t m);
    isCompare = m[`CAP_MM_COMPARATOR_ENABLE] & m[`CAP_MM_MAT] & ~m[`CAP_MM_PWM];
  endfunction
endpackage

`default_nettype wire

// *** logic/cap_count_if.sv ***
`default_nettype none

interface cap_count_if;
  logic [15:0] count;
  logic tick;
  logic advanced;
  modport src(output count, output tick, output advanced);
  modport sink(input count, input tick, input advanced);
endinterface

`default_nettype wire

// *** logic/cap_tick_gen.sv ***
`default_nettype none
`include "cap_cfg.svh"

module cap_tick_gen (
  input wire logic clk_sys,
  input wire logic rst,
  input wire cap_pkg::cap_src_e src,
  input wire logic timer0Overflow,
  input wire logic extCountIn,
  output logic tick
);
  logic [3:0] prescale;
  logic extPrev;
  wire [3:0] divide = (src == cap_pkg::CAP_SRC_DIV4) ? `CAP_DIV4 : `CAP_DIV12;
  wire preDone = (prescale == divide - 4'h1);
  wire extRise = extCountIn & ~extPrev;
  logic next_tick;

  always_comb begin
    case (src)
      cap_pkg::CAP_SRC_DIV12: next_tick = preDone;
      cap_pkg::CAP_SRC_DIV4: next_tick = preDone;
      cap_pkg::CAP_SRC_T0: next_tick = timer0Overflow;
      cap_pkg::CAP_SRC_EXT: next_tick = extRise;
      default: next_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prescale <= 4'h0;
      extPrev <= 1'b0;
      tick <= 1'b0;
    end else begin
      prescale <= preDone ? 4'h0 : prescale + 4'h1;
      extPrev <= extCountIn;
      tick <= next_tick;
    end
  end
endmodule // cap_tick_gen

`default_nettype wire

// *** logic/cap_compare_module.sv ***
`default_nettype none
`include "cap_cfg.svh"

module cap_compare_module #(
  parameter bit IS_WDOG = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  cap_count_if.sink cnt,
  input wire logic wrMode,
  input wire logic wrLow,
  input wire logic wrHigh,
  input wire cap_pkg::cap_byte_t wrData,
  output cap_pkg::cap_byte_t mode,
  output cap_pkg::cap_byte_t cmpLow,
  output cap_pkg::cap_byte_t cmpHigh,
  output logic pin,
  output logic pinOe,
  output logic matchEvent,
  output logic wdogMatch
);
  logic armed;
  wire pwmOn = cap_pkg::isPwm(mode);
  wire cmpOn = cap_pkg::isCompare(mode);
  wire equalNow = cnt.advanced & armed & (cnt.count == {cmpHigh, cmpLow});
  wire match = equalNow & cmpOn;
  // Reload right on the tick that wraps the low byte
  wire reload = pwmOn & cnt.tick & (cnt.count[7:0] == `CAP_LOW_MAX);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode <= `CAP_RST_BYTE;
      cmpLow <= `CAP_RST_BYTE;
      cmpHigh <= `CAP_RST_BYTE;
      armed <= 1'b1;
      pin <= 1'b0;
      pinOe <= 1'b0;
      matchEvent <= 1'b0;
      wdogMatch <= 1'b0;
    end else begin
      if (wrMode) mode <= wrData;
      if (wrLow) cmpLow <= wrData;
      else if (reload) cmpLow <= cmpHigh;
      if (wrHigh) cmpHigh <= wrData;
      if (wrLow) armed <= 1'b0;
      else if (wrHigh) armed <= 1'b1;
      if (pwmOn) pin <= (cnt.count[7:0] >= cmpLow);
      else if (match & mode[`CAP_MM_TOG]) pin <= ~pin;
      pinOe <= pwmOn | (cmpOn & mode[`CAP_MM_TOG]);
      matchEvent <= match;
      wdogMatch <= IS_WDOG & match;
    end
  end
endmodule // cap_compare_module

`default_nettype wire

// *** logic/cap_top.sv ***
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`default_nettype none
`include "cap_cfg.svh"

module cap_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer0Overflow,
  input wire logic extCountIn,
  output logic [4:0] moduleIoPin,
  output logic [4:0] moduleIoPinOe,
  output logic internalReset,
  output logic irq
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire busReq = wb_cyc_i & wb_stb_i;
  // Writes commit on the edge the master sees ack
  wire busWrite = busReq & wb_we_i & wb_ack_o;
  wire [2:0] group = wb_adr_i[7:5];
  wire [2:0] slot = wb_adr_i[4:2];
  wire ctrlHit = (group == `CAP_GRP_CTRL) & ~wb_adr_i[4];
  wire wrLane0 = busWrite & wb_sel_i[0];
  wire wrLane1 = busWrite & wb_sel_i[1];
  wire wrCmode = wrLane0 & ctrlHit & (slot == `CAP_OFS_CMODE);
  wire wrCountL = wrLane0 & ctrlHit & (slot == `CAP_OFS_COUNT);
  wire wrCountH = wrLane1 & ctrlHit & (slot == `CAP_OFS_COUNT);
  wire wrStat = wrLane0 & ctrlHit & (slot == `CAP_OFS_STAT);
  wire wrMask = wrLane0 & ctrlHit & (slot == `CAP_OFS_MASK);
  wire [7:0] wrByte = wb_dat_i[7:0];

  function automatic logic modWrite(input logic [2:0] grp, input logic [2:0] idx);
    modWrite = wrLane0 & (group == grp) & (slot == idx);
  endfunction

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  cap_pkg::cap_byte_t counterMode;
  logic [15:0] count;
  logic countAdvanced;
  logic [6:0] status;
  logic [6:0] mask;
  logic [6:0] next_status;
  logic rawTick;

  wire running = counterMode[`CAP_CM_RUN];
  wire wdogEnable = counterMode[`CAP_CM_WATCHDOG_RESET_ENABLE];
  wire cap_pkg::cap_src_e srcSel = cap_pkg::cap_src_e'(counterMode[`CAP_CM_SRC_MSB:`CAP_CM_SRC_LSB]);
  wire runTick = running & rawTick;
  wire countWrap = runTick & (count == `CAP_CNT_MAX);

  // ----------------------------------------
  // Counter clock source
  // ----------------------------------------
  cap_tick_gen u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .src(srcSel),
    .timer0Overflow(timer0Overflow),
    .extCountIn(extCountIn),
    .tick(rawTick)
  );

  // ----------------------------------------
  // Shared time base
  // ----------------------------------------
  cap_count_if cntBus ();
  assign cntBus.count = count;
  assign cntBus.tick = runTick;
  assign cntBus.advanced = countAdvanced;

  // ----------------------------------------
  // Compare modules
  // ----------------------------------------
  cap_pkg::cap_byte_t modeArr [`CAP_NMOD];
  cap_pkg::cap_byte_t lowArr [`CAP_NMOD];
  cap_pkg::cap_byte_t highArr [`CAP_NMOD];
  logic [4:0] pinVec;
  logic [4:0] oeVec;
  logic [4:0] matchVec;
  logic [4:0] wdogVec;
  logic [4:0] eccfVec;

  genvar gi;
  generate
    for (gi = 0; gi < `CAP_NMOD; gi = gi + 1) begin : g_mod
      cap_compare_module #(
        .IS_WDOG(gi == `CAP_WDOG_IDX)
      ) u_cmp (
        .clk_sys(clk_sys),
        .rst(rst),
        .cnt(cntBus.sink),
        .wrMode(modWrite(`CAP_GRP_MMODE, 3'(gi))),
        .wrLow(modWrite(`CAP_GRP_CMPL, 3'(gi))),
        .wrHigh(modWrite(`CAP_GRP_CMPH, 3'(gi))),
        .wrData(wrByte),
        .mode(modeArr[gi]),
        .cmpLow(lowArr[gi]),
        .cmpHigh(highArr[gi]),
        .pin(pinVec[gi]),
        .pinOe(oeVec[gi]),
        .matchEvent(matchVec[gi]),
        .wdogMatch(wdogVec[gi])
      );
      // Interrupt enable gates only the flag, never the pin
      assign eccfVec[gi] = modeArr[gi][`CAP_MM_ECCF];
    end
  endgenerate

  assign moduleIoPin = pinVec;
  assign moduleIoPinOe = oeVec;

  // ----------------------------------------
  // Watchdog reset
  // ----------------------------------------
  // Internal only; there is no path to the external reset pin
  wire wdogFire = wdogVec[`CAP_WDOG_IDX] & wdogEnable;

  // ----------------------------------------
  // Event status, set wins over clear
  // ----------------------------------------
  wire [6:0] events = {wdogFire, countWrap, matchVec & eccfVec};
  wire [6:0] clearBits = wrStat ? wb_dat_i[6:0] : 7'h00;

  always_comb begin
    next_status = (status & ~clearBits) | events;
  end

  // ----------------------------------------
  // Register updates
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      counterMode <= `CAP_RST_BYTE;
      mask <= `CAP_RST_STAT;
      status <= `CAP_RST_STAT;
      irq <= 1'b0;
      internalReset <= 1'b0;
    end else begin
      if (wrCmode) counterMode <= wrByte;
      if (wrMask) mask <= wb_dat_i[6:0];
      status <= next_status;
      irq <= |(next_status & mask);
      internalReset <= wdogFire;
    end
  end

  // Bus writes to the counter win over the increment
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count <= 16'h0000;
      countAdvanced <= 1'b0;
    end else begin
      if (wrCountL | wrCountH) begin
        if (wrCountL) count[7:0] <= wrByte;
        if (wrCountH) count[15:8] <= wb_dat_i[15:8];
      end else if (runTick) begin
        count <= count + 16'h0001;
      end
      countAdvanced <= runTick | wrCountL | wrCountH;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire modHit = (slot < 3'(`CAP_NMOD));
  logic [31:0] readWord;

  always_comb begin
    readWord = 32'h0000_0000;
    case (group)
      `CAP_GRP_CTRL: begin
        if (ctrlHit) begin
          case (slot)
            `CAP_OFS_CMODE: readWord = {24'h000000, counterMode};
            `CAP_OFS_COUNT: readWord = {16'h0000, count};
            `CAP_OFS_STAT: readWord = {25'h0000000, status};
            `CAP_OFS_MASK: readWord = {25'h0000000, mask};
            default: readWord = 32'h0000_0000;
          endcase
        end
      end
      `CAP_GRP_MMODE: if (modHit) readWord = {24'h000000, modeArr[slot]};
      `CAP_GRP_CMPL: if (modHit) readWord = {24'h000000, lowArr[slot]};
      `CAP_GRP_CMPH: if (modHit) readWord = {24'h000000, highArr[slot]};
      default: readWord = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Bus answer: one wait, ack for one cycle
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
      if (busReq & ~wb_ack_o) wb_dat_o <= readWord;
    end
  end
endmodule // cap_top

`default_nettype wire

// *** verification/cap_top_checker.sv ***
`default_nettype none
module cap_top_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [4:0] moduleIoPinOe,
  input wire logic internalReset,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Shadow of written registers
  // ----------------------------------------
  logic [7:0] cmode;
  logic [7:0] mode4;
  logic [7:0] mask;
  wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  always_ff @(posedge clk_sys) begin
    if (rst) {cmode, mode4, mask} <= 24'h0;
    else if (wr && wb_adr_i == 8'h00) cmode <= wb_dat_i[7:0];
    else if (wr && wb_adr_i == 8'h30) mode4 <= wb_dat_i[7:0];
    else if (wr && wb_adr_i == 8'h0c) mask <= wb_dat_i[7:0];
  end
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without strobe");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hfc |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  wdog_pulse_a: assert property (internalReset |=> !internalReset)
    else $error("reset pulse too long");
  wdog_gate_a: assert property (internalReset |-> $past(cmode[6]))
    else $error("reset with enable clear");
  wdog_mode_a: assert property (internalReset |-> $past(mode4[6] & mode4[3] & ~mode4[1]))
    else $error("reset outside compare mode");
  irq_mask_a: assert property (irq |-> mask != 8'h0 || $past(mask) != 8'h0)
    else $error("irq while all masked");
  pin_drive_a: assert property (moduleIoPinOe[4] |-> mode4[6] || $past(mode4[6]))
    else $error("pin driven while comparator off");
  cover property (internalReset);
  cover property (irq);
  cover property (moduleIoPinOe[0]);
endmodule // cap_top_checker

bind cap_top cap_top_checker chk_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .moduleIoPinOe(moduleIoPinOe),
  .internalReset(internalReset), .irq(irq));
`default_nettype wire

// *** verification/cap_load_model.sv ***
`default_nettype none
module cap_load_model (
  input wire logic clk_sys,
  input wire logic clear,
  input wire logic drive,
  input wire logic enable,
  output logic [15:0] highCnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Load with pull-down, counts high cycles
  // ----------------------------------------
  wire logic level = enable & drive;
  always_ff @(posedge clk_sys) begin
    if (clear) highCnt <= 16'h0;
    else if (level) highCnt <= highCnt + 16'h1;
  end
endmodule // cap_load_model
`default_nettype wire

// *** verification/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic tOvf = 1'b0, extIn = 1'b0, clr = 1'b0, ack, intRst, irq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [3:0] sel = 4'h0;
  logic [4:0] pin, pinOe;
  logic [15:0] hi0, hi1;
  logic [2:0] divCnt = 3'h0;
  int error_cnt = 0, n_checks = 0, wdCnt = 0;
  always #20 clk_sys = ~clk_sys;
  // ----------------------------------------
  // Counter sources, one count per 8 cycles
  // ----------------------------------------
  always @(posedge clk_sys) begin
    divCnt <= divCnt + 3'h1;
    tOvf <= (divCnt == 3'h7);
    extIn <= divCnt[2];
    if (intRst) wdCnt <= wdCnt + 1;
  end
  cap_top dut_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer0Overflow(tOvf), .extCountIn(extIn), .moduleIoPin(pin), .moduleIoPinOe(pinOe),
    .internalReset(intRst), .irq(irq));
  cap_load_model load0_u (.clk_sys(clk_sys), .clear(clr), .drive(pin[0]), .enable(pinOe[0]), .highCnt(hi0));
  cap_load_model load1_u (.clk_sys(clk_sys), .clear(clr), .drive(pin[1]), .enable(pinOe[1]), .highCnt(hi1));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
    @(posedge clk_sys);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk_sys);
    if (n == 20) check("bus ack", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'h1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0, 4'hf);
    check(what, exp, q);
  endtask
  task automatic t_regs;
    logic [7:0] regs[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h60};
    foreach (regs[i]) rdchk(regs[i], 32'h0, "reset value");
    wr(8'hfc, 8'h5a);
    rdchk(8'hfc, 32'h0, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_pwm;
    int div[4] = '{12, 4, 8, 8};
    wr(8'h20, 8'h42);
    wr(8'h24, 8'h42);
    wr(8'h60, 8'hc0);
    wr(8'h64, 8'h00);
    rdchk(8'h40, 32'h0, "low before wrap");
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, {5'h0, s[1:0], 1'b1});
      tick(256 * div[s] + 40);
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      tick(256 * div[s] + 1);
      check("duty high cycles", 64 * div[s], {16'h0, hi0});
      check("zero compare high", 256 * div[s], {16'h0, hi1});
    end
    rdchk(8'h40, 32'hc0, "low after wrap");
    // Keep the counter running so the hold is a real mid-period test
    wr(8'h00, 8'h03);
    bus(1'b1, 8'h04, 32'h0010, 4'h3);
    wr(8'h60, 8'h80);
    tick(100);
    rdchk(8'h40, 32'hc0, "low held mid period");
    tick(256 * 4);
    rdchk(8'h40, 32'h80, "low after next wrap");
    $display("test pwm done");
  endtask
  task automatic t_wdog;
    wr(8'h0c, 8'h40);
    wr(8'h30, 8'h4c);
    bus(1'b1, 8'h04, 32'h1000, 4'h3);
    wr(8'h50, 8'h08);
    wr(8'h70, 8'h10);
    wr(8'h00, 8'h03);
    tick(100);
    check("reset with enable clear", 0, wdCnt);
    check("module4 toggled", 1, {31'h0, pin[4]});
    wr(8'h00, 8'h40);
    bus(1'b1, 8'h04, 32'h1000, 4'h3);
    wr(8'h50, 8'h08);
    wr(8'h00, 8'h43);
    tick(100);
    check("reset while disarmed", 0, wdCnt);
    wr(8'h00, 8'h40);
    bus(1'b1, 8'h04, 32'h1000, 4'h3);
    wr(8'h70, 8'h10);
    wr(8'h00, 8'h43);
    tick(100);
    check("watchdog reset", 1, wdCnt);
    rdchk(8'h30, 32'h4c, "mode kept");
    rdchk(8'h08, 32'h40, "status");
    check("irq raised", 1, {31'h0, irq});
    wr(8'h0c, 8'h00);
    tick(2);
    check("irq masked", 0, {31'h0, irq});
    wr(8'h0c, 8'h40);
    tick(2);
    check("irq unmasked", 1, {31'h0, irq});
    wr(8'h08, 8'h40);
    tick(2);
    check("irq cleared", 0, {31'h0, irq});
    rdchk(8'h08, 32'h0, "status cleared");
    // Refresh from the main sequence: low zero, high from the live count
    bus(1'b0, 8'h04, 32'h0, 4'hf);
    wr(8'h50, 8'h00);
    wr(8'h70, q[15:8]);
    tick(100);
    check("reset after refresh", 1, wdCnt);
    $display("test watchdog done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    tick(4);
    rst <= 1'b0;
    tick(1);
    t_regs;
    t_pwm;
    t_wdog;
    close_out;
  end
  initial begin
    tick(40000);
    error_cnt++;
    close_out;
  end
endmodule // testbench
`default_nettype wire
